// ===== verilog/uwc_pkg.sv
// Shared constants and types for the unified write-through cache
package uwc_pkg;
  localparam int UWC_LINES = 256;
  localparam int UWC_WAY_LINES = 128;
  localparam int UWC_TAG_W = 23;
  localparam int UWC_WB_DEPTH = 2;
  localparam logic [1:0] UWC_WB_FULL = 2'h2;
  localparam logic [1:0] UWC_WB_EMPTY = 2'h0;
  localparam int UWC_TAG_LSB = 9;
  localparam int UWC_DM_IDX_MSB = 9;
  localparam int UWC_SA_IDX_MSB = 8;
  localparam int UWC_IDX_LSB = 2;
  localparam int UWC_HALF_BIT = 1;
  localparam logic [3:0] UWC_BE_ALL = 4'hf;
  localparam logic [3:0] UWC_BE_NONE = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WR = 3'b010,
    ST_RD = 3'b100
  } uwc_state_e;

  typedef struct packed {
    uwc_state_e st;
    logic enabled;
    logic two_way_q;
    logic [UWC_LINES-1:0] valid;
    logic [UWC_LINES-1:0][UWC_TAG_W-1:0] tag;
    logic [UWC_LINES-1:0][31:0] data;
    logic [UWC_WAY_LINES-1:0] lru;
    logic [1:0] wb_cnt;
    logic [UWC_WB_DEPTH-1:0][31:0] wb_addr;
    logic [UWC_WB_DEPTH-1:0][3:0] wb_be;
    logic [UWC_WB_DEPTH-1:0][31:0] wb_data;
    logic rd_pend;
    logic [31:0] rd_addr;
    logic half;
    logic cyc;
    logic [15:0] rbuf;
    logic rsp_valid;
    logic rsp_hit;
    logic [31:0] rsp_data;
    logic bus_req;
    logic bus_write;
    logic [31:0] bus_addr;
    logic [3:0] bus_be;
    logic [31:0] bus_wdata;
  } uwc_state_s;
endpackage

// ===== verilog/uwc_cache.sv
// Unified write-through cache with two-deep posted write buffer
`timescale 1ns/10ps
module uwc_cache
  import uwc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cache_enable,
  input wire logic two_way,
  input wire logic narrow_bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [3:0] req_be,
  input wire logic [31:0] req_wdata,
  output logic rsp_valid,
  output logic rsp_hit,
  output logic [31:0] rsp_data,
  output logic bus_req,
  output logic bus_write,
  output logic [31:0] bus_addr,
  output logic [3:0] bus_be,
  output logic [31:0] bus_wdata,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata
);

  uwc_state_s s;
  uwc_state_s next_s;
  logic cfg_stable;
  logic acc;
  logic [6:0] idx7;
  logic [7:0] line_a;
  logic [7:0] line_b;
  logic [7:0] hit_line;
  logic hit_a;
  logic hit_b;
  logic hit;
  logic pop;
  logic [0:0] push_idx;
  logic [31:0] rd_word;
  logic [6:0] rd_idx;
  logic vic_way;
  logic [7:0] alloc_line;

  ////////////////////////////////////////////////////////////////////////////////
  // Lookup, runs in the same cycle as the request

  assign cfg_stable = (two_way == s.two_way_q);
  assign idx7 = req_addr[UWC_SA_IDX_MSB:UWC_IDX_LSB];
  assign line_a = two_way ? {1'b0, idx7} : req_addr[UWC_DM_IDX_MSB:UWC_IDX_LSB];
  assign line_b = {1'b1, idx7};
  assign hit_a = s.enabled && cfg_stable && s.valid[line_a] &&
    (s.tag[line_a] == req_addr[31:UWC_TAG_LSB]);
  assign hit_b = two_way && s.enabled && cfg_stable && s.valid[line_b] &&
    (s.tag[line_b] == req_addr[31:UWC_TAG_LSB]);
  assign hit = hit_a || hit_b;
  assign hit_line = hit_b ? line_b : line_a;
  // Reads wait behind a pending miss, which keeps fills and hits from racing
  assign req_ready = !s.rd_pend && !(req_write && (s.wb_cnt == UWC_WB_FULL));
  assign acc = req_valid && req_ready;

  assign rd_word = narrow_bus ? {bus_rdata[15:0], s.rbuf} : bus_rdata;
  assign rd_idx = s.rd_addr[UWC_SA_IDX_MSB:UWC_IDX_LSB];
  // Fill an empty way first, otherwise the least recently used one
  assign vic_way = !s.valid[{1'b0, rd_idx}] ? 1'b0 :
    (!s.valid[{1'b1, rd_idx}] ? 1'b1 : s.lru[rd_idx]);
  assign alloc_line = two_way ? {vic_way, rd_idx} :
    s.rd_addr[UWC_DM_IDX_MSB:UWC_IDX_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;
    pop = 1'b0;
    next_s.rsp_valid = 1'b0;
    next_s.rsp_hit = 1'b0;
    next_s.enabled = cache_enable;
    next_s.two_way_q = two_way;
    if (!cfg_stable) begin
      next_s.valid = '0;
    end
    case (s.st)
      ST_IDLE: begin
        next_s.cyc = 1'b0;
        next_s.half = 1'b0;
        if (s.wb_cnt != UWC_WB_EMPTY) begin
          next_s.st = ST_WR;
          next_s.bus_req = 1'b1;
          next_s.bus_write = 1'b1;
          next_s.bus_addr = {s.wb_addr[0][31:2], 2'b00};
          next_s.bus_be = narrow_bus ? {2'b00, s.wb_be[0][1:0]} : s.wb_be[0];
          next_s.bus_wdata = narrow_bus ? {16'h0000, s.wb_data[0][15:0]} : s.wb_data[0];
        end else if (s.rd_pend) begin
          next_s.st = ST_RD;
          next_s.bus_req = 1'b1;
          next_s.bus_write = 1'b0;
          next_s.bus_addr = {s.rd_addr[31:2], 2'b00};
          next_s.bus_be = narrow_bus ? {2'b00, UWC_BE_ALL[1:0]} : UWC_BE_ALL;
          next_s.bus_wdata = 32'h0000_0000;
        end
      end
      ST_WR, ST_RD: begin
        next_s.cyc = 1'b1;
        // An acknowledge in the first bus cycle is ignored
        if (bus_ack && s.cyc) begin
          next_s.cyc = 1'b0;
          if (narrow_bus && !s.half) begin
            next_s.half = 1'b1;
            next_s.rbuf = bus_rdata[15:0];
            next_s.bus_addr[UWC_HALF_BIT] = 1'b1;
            next_s.bus_be = {2'b00, (s.st == ST_WR) ? s.wb_be[0][3:2] : UWC_BE_ALL[3:2]};
            next_s.bus_wdata = {16'h0000, s.wb_data[0][31:16]};
          end else begin
            next_s.st = ST_IDLE;
            next_s.bus_req = 1'b0;
            next_s.bus_be = UWC_BE_NONE;
            if (s.st == ST_WR) begin
              pop = 1'b1;
            end else begin
              next_s.rd_pend = 1'b0;
              next_s.rsp_valid = 1'b1;
              next_s.rsp_data = rd_word;
              if (s.enabled && cfg_stable) begin
                next_s.valid[alloc_line] = 1'b1;
                next_s.tag[alloc_line] = s.rd_addr[31:UWC_TAG_LSB];
                next_s.data[alloc_line] = rd_word;
                if (two_way) begin
                  next_s.lru[rd_idx] = !vic_way;
                end
              end
            end
          end
        end
      end
      default: begin
        next_s.st = ST_IDLE;
        next_s.bus_req = 1'b0;
      end
    endcase
    if (pop) begin
      next_s.wb_addr[0] = s.wb_addr[1];
      next_s.wb_be[0] = s.wb_be[1];
      next_s.wb_data[0] = s.wb_data[1];
    end
    push_idx = 1'(s.wb_cnt - {1'b0, pop});
    next_s.wb_cnt = s.wb_cnt - {1'b0, pop};
    if (acc && req_write) begin
      next_s.wb_addr[push_idx] = req_addr;
      next_s.wb_be[push_idx] = req_be;
      next_s.wb_data[push_idx] = req_wdata;
      next_s.wb_cnt = 2'(next_s.wb_cnt + 2'h1);
      if (hit) begin
        for (int i = 0; i < 4; i++) begin
          if (req_be[i]) begin
            next_s.data[hit_line][8*i +: 8] = req_wdata[8*i +: 8];
          end
        end
      end
    end else if (acc) begin
      if (hit) begin
        next_s.rsp_valid = 1'b1;
        next_s.rsp_hit = 1'b1;
        next_s.rsp_data = s.data[hit_line];
        if (two_way) begin
          next_s.lru[idx7] = hit_a;
        end
      end else begin
        next_s.rd_pend = 1'b1;
        next_s.rd_addr = req_addr;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.st <= ST_IDLE;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign rsp_valid = s.rsp_valid;
  assign rsp_hit = s.rsp_hit;
  assign rsp_data = s.rsp_data;
  assign bus_req = s.bus_req;
  assign bus_write = s.bus_write;
  assign bus_addr = s.bus_addr;
  assign bus_be = s.bus_be;
  assign bus_wdata = s.bus_wdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence read_hit_s;
    ce && acc && !req_write && hit;
  endsequence
  sequence bus_start_s;
    $rose(bus_req);
  endsequence

  wb_depth_a: assert property (s.wb_cnt <= UWC_WB_FULL)
    else $error("write buffer over two entries");
  wt_post_a: assert property (ce && acc && req_write |=> s.wb_cnt != UWC_WB_EMPTY)
    else $error("write not posted");
  no_wr_alloc_a: assert property (ce && s.st == ST_WR && cfg_stable |=> $stable(s.valid))
    else $error("write cycle changed valid bits");
  bus_min_a: assert property (bus_start_s |=> bus_req)
    else $error("bus access shorter than two cycles");
  hit_rsp_a: assert property (read_hit_s |=> rsp_valid && rsp_hit)
    else $error("hit not answered next cycle");
  // A full buffer may still hold off the next write; that is not a stall from the hit
  hit_nostall_a: assert property (read_hit_s |=> !s.rd_pend &&
    (req_ready || (req_write && s.wb_cnt == UWC_WB_FULL)))
    else $error("hit caused a stall");
  narrow_bus_a: assert property (narrow_bus && bus_req |-> bus_be[3:2] == 2'b00)
    else $error("narrow bus moved more than 16 bits");
  reset_inv_a: assert property ($past(rst) |-> s.valid == '0 && !s.enabled)
    else $error("reset left lines valid or cache enabled");
  cfg_inv_a: assert property (ce && !cfg_stable |=> s.valid == '0)
    else $error("organisation change did not invalidate");
  lru_hit_a: assert property (read_hit_s and (two_way && hit_a && !hit_b)
    |=> s.lru[$past(idx7)])
    else $error("lru not updated on way 0 hit");

endmodule // uwc_cache

// ===== verification/uwc_mem_model.sv
// Bus-side memory model answering the cache's bus cycles
`timescale 1ns/10ps
module uwc_mem_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic narrow,
  input wire logic [3:0] wt,
  input wire logic bus_req,
  input wire logic [31:0] bus_addr,
  output logic bus_ack,
  output logic [31:0] bus_rdata,
  output logic [7:0] acks
);
  logic [3:0] cnt;
  logic [31:0] w;
  assign w = {bus_addr[31:2], 2'b00} ^ 32'h5a5a_0f0f;
  always_ff @(posedge mclk) begin
    acks <= rst ? 8'h00 : acks + {7'h00, bus_ack};
    if (rst) begin
      cnt <= 4'h0;
      bus_ack <= 1'b0;
      bus_rdata <= 32'h0000_0000;
    end else if (!bus_req || bus_ack) begin
      // Released data toggles so a sample one cycle late never looks right
      cnt <= 4'h0;
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
    end else if (cnt == wt) begin
      bus_ack <= 1'b1;
      bus_rdata <= narrow ? {~w[15:0], bus_addr[1] ? w[31:16] : w[15:0]} : w;
    end else begin
      cnt <= cnt + 4'h1;
      bus_rdata <= ~bus_rdata;
    end
  end
endmodule // uwc_mem_model

// ===== verification/test_uwc_cache.sv
// Self-checking bench for the unified write-through cache
`timescale 1ns/10ps
module test_uwc_cache;
  import uwc_pkg::*;
  logic mclk, rst, cache_enable, two_way, narrow_bus, req_valid, req_write, bus_ack;
  logic req_ready, rsp_valid, rsp_hit, bus_req, bus_write;
  logic [31:0] req_addr, req_wdata, rsp_data, bus_addr, bus_wdata, bus_rdata;
  logic [3:0] req_be, bus_be, wt;
  logic [7:0] acks, a0;
  int errors, checked;
  uwc_cache i_uwc_cache (.mclk, .rst, .ce(1'b1), .cache_enable, .two_way, .narrow_bus,
    .req_valid, .req_ready, .req_write, .req_addr, .req_be, .req_wdata, .rsp_valid,
    .rsp_hit, .rsp_data, .bus_req, .bus_write, .bus_addr, .bus_be, .bus_wdata,
    .bus_ack, .bus_rdata);
  uwc_mem_model i_uwc_mem_model (.mclk, .rst, .narrow(narrow_bus), .wt, .bus_req,
    .bus_addr, .bus_ack, .bus_rdata, .acks);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] mw(input logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'h5a5a_0f0f;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic w, input logic [31:0] a, input logic [3:0] be,
    input logic [31:0] d);
    @(negedge mclk);
    {req_valid, req_write, req_addr, req_be, req_wdata} = {1'b1, w, a, be, d};
    while (req_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
  endtask
  // Hit must answer at the first negedge, with no bus cycle at all
  task automatic rd(input logic [31:0] a, input logic h, input logic [31:0] d, input int n);
    int k;
    a0 = acks;
    k = 1;
    put(1'b0, a, UWC_BE_ALL, 32'h0);
    @(negedge mclk) req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && k < 40) begin
      k++;
      @(negedge mclk);
    end
    chk({22'h0, rsp_hit, k == 1, acks - a0}, {22'h0, h, h, n[7:0]});
    chk(rsp_data, d);
  endtask
  task automatic wr(input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
    int k;
    k = 0;
    put(1'b1, a, be, d);
    @(negedge mclk) req_valid = 1'b0;
    while (bus_req !== 1'b1 && k < 4) begin
      k++;
      @(negedge mclk);
    end
    chk({bus_addr[31:2], bus_req, bus_write}, {a[31:2], 2'b11});
    chk({26'h0, bus_addr[1:0], bus_be}, {26'h0, 2'b00, be});
    chk(bus_wdata, d);
    repeat (20) @(negedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({29'h0, req_ready, bus_req, rsp_valid}, 32'h0000_0004);
    rd(32'h0000_03fc, 1'b0, mw(32'h0000_03fc), 1);
    rd(32'h0000_03fc, 1'b0, mw(32'h0000_03fc), 1);
    @(negedge mclk) cache_enable = 1'b1;
    repeat (2) @(negedge mclk);
    $display("reset test done");
  endtask
  task automatic t_dm;
    rd(32'h0000_03fc, 1'b0, mw(32'h0000_03fc), 1);
    rd(32'h0000_03fc, 1'b1, mw(32'h0000_03fc), 0);
    rd(32'h0000_07fc, 1'b0, mw(32'h0000_07fc), 1);
    rd(32'h0000_03fc, 1'b0, mw(32'h0000_03fc), 1);
    wr(32'h0000_0100, UWC_BE_ALL, 32'h0000_0001);
    rd(32'h0000_0100, 1'b0, mw(32'h0000_0100), 1);
    wr(32'h0000_03fc, 4'h3, 32'h1122_3344);
    rd(32'h0000_03fc, 1'b1, (mw(32'h0000_03fc) & 32'hffff_0000) | 32'h3344, 0);
    $display("direct-mapped test done");
  endtask
  task automatic t_sa;
    @(negedge mclk) two_way = 1'b1;
    repeat (2) @(negedge mclk);
    rd(32'h0000_03fc, 1'b0, mw(32'h0000_03fc), 1);
    rd(32'h0000_07fc, 1'b0, mw(32'h0000_07fc), 1);
    rd(32'h0000_03fc, 1'b1, mw(32'h0000_03fc), 0);
    rd(32'h0000_07fc, 1'b1, mw(32'h0000_07fc), 0);
    rd(32'h0000_05fc, 1'b0, mw(32'h0000_05fc), 1);
    rd(32'h0000_07fc, 1'b1, mw(32'h0000_07fc), 0);
    rd(32'h0000_03fc, 1'b0, mw(32'h0000_03fc), 1);
    $display("two-way test done");
  endtask
  task automatic t_narrow;
    int k;
    @(negedge mclk) narrow_bus = 1'b1;
    rd(32'h0000_1010, 1'b0, mw(32'h0000_1010), 2);
    rd(32'h0000_1010, 1'b1, mw(32'h0000_1010), 0);
    // Write hit on upper bytes: low half goes first, then the high half
    k = 0;
    put(1'b1, 32'h0000_1010, 4'hc, 32'h5566_7788);
    @(negedge mclk) req_valid = 1'b0;
    while (bus_req !== 1'b1 && k < 4) begin
      k++;
      @(negedge mclk);
    end
    chk({24'h0, bus_req, bus_write, bus_addr[1:0], bus_be}, 32'h0000_00c0);
    chk(bus_wdata, 32'h0000_7788);
    while (bus_addr[1] !== 1'b1 && k < 8) begin
      k++;
      @(negedge mclk);
    end
    chk({24'h0, bus_req, bus_write, bus_addr[1:0], bus_be}, 32'h0000_00e3);
    chk(bus_wdata, 32'h0000_5566);
    repeat (10) @(negedge mclk);
    rd(32'h0000_1010, 1'b1, (mw(32'h0000_1010) & 32'h0000_ffff) | 32'h5566_0000, 0);
    @(negedge mclk) narrow_bus = 1'b0;
    $display("narrow test done");
  endtask
  // Lines filled before a reset must all miss after it
  task automatic t_reset_mid;
    @(negedge mclk) {rst, cache_enable} = 2'b10;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    chk({29'h0, req_ready, bus_req, rsp_valid}, 32'h0000_0004);
    @(negedge mclk) cache_enable = 1'b1;
    repeat (2) @(negedge mclk);
    rd(32'h0000_1010, 1'b0, mw(32'h0000_1010), 1);
    rd(32'h0000_1010, 1'b1, mw(32'h0000_1010), 0);
    $display("mid-run reset test done");
  endtask
  // Slow bus keeps the first write busy so the buffer must fill
  task automatic t_wbuf;
    wt = 4'h6;
    a0 = acks;
    put(1'b1, 32'h0000_2000, UWC_BE_ALL, 32'h0000_0001);
    #1 chk({31'h0, req_ready}, 32'h1);
    put(1'b1, 32'h0000_2004, UWC_BE_ALL, 32'h0000_0002);
    put(1'b1, 32'h0000_2008, UWC_BE_ALL, 32'h0000_0003);
    #1 chk({31'h0, req_ready}, 32'h0);
    put(1'b1, 32'h0000_200c, UWC_BE_ALL, 32'h0000_0004);
    @(negedge mclk) req_valid = 1'b0;
    repeat (60) @(negedge mclk);
    chk({24'h0, acks - a0}, 32'h4);
    wt = 4'h0;
    $display("write buffer test done");
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    {rst, cache_enable, two_way, narrow_bus, req_valid, req_write} = 6'b10_0000;
    {req_addr, req_be, req_wdata, wt} = '0;
    errors = 0;
    checked = 0;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    t_reset;
    t_dm;
    t_sa;
    t_narrow;
    t_reset_mid;
    t_wbuf;
    tally_and_finish;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    tally_and_finish;
  end
endmodule // test_uwc_cache
